// [pkg/exu_params.svh]
`ifndef EXU_PARAMS_SVH
`define EXU_PARAMS_SVH

// Register byte offsets on the bus.
`define EXU_OFS_INSTR  8'h00
`define EXU_OFS_ACC    8'h04
`define EXU_OFS_FLAGS  8'h08
`define EXU_OFS_PC     8'h0c
`define EXU_OFS_MADDR  8'h10
`define EXU_OFS_MDATA  8'h14
`define EXU_OFS_STATUS 8'h18
`define EXU_OFS_IRQC   8'h1c
`define EXU_OFS_WAKE   8'h20
`define EXU_OFS_STACK  8'h24

// Flag register bit positions.
`define EXU_FLG_C   0
`define EXU_FLG_AC  1
`define EXU_FLG_Z   2
`define EXU_FLG_OV  3
`define EXU_FLG_PWR_DOWN   4
`define EXU_FLG_WD_TIMEOUT 5
`define EXU_FLG_TC1 6
`define EXU_FLG_TC2 7

// Instruction word fields.
`define EXU_F_OP_LSB  0
`define EXU_F_OP_W    5
`define EXU_F_MA_LSB  8
`define EXU_F_ARG_LSB 16
`define EXU_JUMP_W    13

// Stack pointer position in the status word.
`define EXU_STAT_SP_LSB 8

`define EXU_GIE_BIT   0
`define EXU_HTRANS_NS 1

// Reset values.
`define EXU_ACC_RST   8'h00
`define EXU_FLAGS_RST 8'h00
`define EXU_IRQC_RST  8'h00

`endif

// [pkg/exu_pkg.sv]
package exu_pkg;

  typedef enum logic [4:0] {
    EXU_IDLE_OP     = 5'h00,
    EXU_MINUS_ONE_MEM = 5'h01,
    EXU_MINUS_ONE_ACC = 5'h02,
    EXU_SLEEP       = 5'h03,
    EXU_INC_MEM     = 5'h04,
    EXU_INC_ACC     = 5'h05,
    EXU_JUMP        = 5'h06,
    EXU_MEM_TO_ACC  = 5'h07,
    EXU_IMM_TO_ACC  = 5'h08,
    EXU_ACC_TO_MEM  = 5'h09,
    EXU_OR_MEM_ACC  = 5'h0a,
    EXU_OR_IMM_ACC  = 5'h0b,
    EXU_OR_TO_MEM   = 5'h0c,
    EXU_POP_PC      = 5'h0d,
    EXU_POP_PC_VAL  = 5'h0e,
    EXU_IRQ_EXIT    = 5'h0f,
    EXU_ROL_MEM     = 5'h10,
    EXU_ROL_ACC     = 5'h11,
    EXU_ROLC_MEM    = 5'h12,
    EXU_ROLC_ACC    = 5'h13,
    EXU_ROR_MEM     = 5'h14,
    EXU_ROR_ACC     = 5'h15
  } exu_op_t;

  typedef enum logic [1:0] {
    EXU_ST_IDLE  = 2'b00,
    EXU_ST_EXEC  = 2'b01,
    EXU_ST_POP   = 2'b10,
    EXU_ST_SLEEP = 2'b11
  } exu_state_t;

endpackage

// [src/exu_alu.sv]
`timescale 1ns/1ps
module exu_alu (
  // Operation and operands
  input  wire exu_pkg::exu_op_t op,
  input  wire logic [7:0]       mem_in,
  input  wire logic [7:0]       acc_in,
  input  wire logic [7:0]       imm_in,
  input  wire logic             c_in,
  // Result and write steering
  output logic [7:0]            res,
  output logic                  wr_acc,
  output logic                  wr_mem,
  output logic                  z_upd,
  output logic                  c_upd,
  output logic                  c_new
);

  always_comb begin
    res    = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    z_upd  = 1'b0;
    c_upd  = 1'b0;
    c_new  = c_in;
    case (op)
      exu_pkg::EXU_MINUS_ONE_MEM: begin
        res    = mem_in - 8'h01;
        wr_mem = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_MINUS_ONE_ACC: begin
        res    = mem_in - 8'h01;
        wr_acc = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_INC_MEM: begin
        res    = mem_in + 8'h01;
        wr_mem = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_INC_ACC: begin
        res    = mem_in + 8'h01;
        wr_acc = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_IMM_TO_ACC, exu_pkg::EXU_POP_PC_VAL: begin
        res    = imm_in;
        wr_acc = 1'b1;
      end
      exu_pkg::EXU_MEM_TO_ACC: begin
        res    = mem_in;
        wr_acc = 1'b1;
      end
      exu_pkg::EXU_ACC_TO_MEM: begin
        res    = acc_in;
        wr_mem = 1'b1;
      end
      exu_pkg::EXU_OR_MEM_ACC: begin
        res    = acc_in | mem_in;
        wr_acc = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_OR_IMM_ACC: begin
        res    = acc_in | imm_in;
        wr_acc = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_OR_TO_MEM: begin
        res    = acc_in | mem_in;
        wr_mem = 1'b1;
        z_upd  = 1'b1;
      end
      exu_pkg::EXU_ROL_MEM: begin
        res    = {mem_in[6:0], mem_in[7]};
        wr_mem = 1'b1;
      end
      exu_pkg::EXU_ROL_ACC: begin
        res    = {mem_in[6:0], mem_in[7]};
        wr_acc = 1'b1;
      end
      exu_pkg::EXU_ROLC_MEM: begin
        res    = {mem_in[6:0], c_in};
        wr_mem = 1'b1;
        c_upd  = 1'b1;
        c_new  = mem_in[7];
      end
      exu_pkg::EXU_ROLC_ACC: begin
        res    = {mem_in[6:0], c_in};
        wr_acc = 1'b1;
        c_upd  = 1'b1;
        c_new  = mem_in[7];
      end
      exu_pkg::EXU_ROR_MEM: begin
        res    = {mem_in[0], mem_in[7:1]};
        wr_mem = 1'b1;
      end
      exu_pkg::EXU_ROR_ACC: begin
        res    = {mem_in[0], mem_in[7:1]};
        wr_acc = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

endmodule

// [src/exu_core.sv]
// What this block does
// - Decrement memory byte in place, Z only
// - Memory minus one into accumulator, Z only
// - Sleep stops execution, keeps RAM and registers
// - Sleep clears watchdog and time-out, sets power-down
// - Increment memory byte in place, Z only
// - Memory plus one into accumulator, Z only
// - Jump replaces PC bits 0 to 12
// - Load immediate byte into accumulator, no flags
// - Copy byte memory/accumulator, flags untouched
// - Idle only advances the program counter
// - OR into accumulator, Z only
// - OR into memory byte, Z only
// - Return pops PC, takes two cycles
// - Return pops PC, loads immediate to accumulator
// - Interrupt return pops PC, sets global enable
// - Rotate memory left in place, no flags
// - Rotate memory left into accumulator, no flags
// - Rotate left through carry in place
// - Rotate left through carry into accumulator
// - Rotate memory right in place, no flags
// - Rotate memory right into accumulator, no flags
`timescale 1ns/1ps
`include "exu_params.svh"
module exu_core #(
  parameter int MEM_AW    = 8,
  parameter int PC_W      = 16,
  parameter int STK_DEPTH = 8,
  parameter int WD_PRE_W  = 8,
  parameter int WD_W      = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Power state
  output logic             power_down
);

  localparam int SP_W = $clog2(STK_DEPTH);

  // Bus pipeline state
  logic             dp_vld_q;
  logic             dp_wr_q;
  logic [7:0]       dp_adr_q;
  logic             hready_q;
  logic [31:0]      hrdata_q;
  logic             hresp_q;
  logic             pdown_q;

  // Architectural state
  logic [7:0]       acc_q;
  logic [7:0]       flags_q;
  logic [7:0]       flags_d;
  logic [PC_W-1:0]  pc_q;
  logic [31:0]      instr_q;
  logic [7:0]       irq_control_reg_q;
  logic [MEM_AW-1:0] maddr_q;
  logic [SP_W-1:0]  sp_q;
  logic [PC_W-1:0]  stk_q [STK_DEPTH];
  logic [7:0]       mem_q [2**MEM_AW];
  logic [WD_PRE_W-1:0] wd_pre_q;
  logic [WD_W-1:0]  watchdog_counter_q;
  exu_pkg::exu_state_t st_q;
  exu_pkg::exu_state_t st_d;

  // Decode and datapath nets
  logic             addr_take;
  logic             wr_hit;
  logic             exec;
  logic             pop_cyc;
  logic             wd_ovf;
  logic             wd_clr;
  logic [31:0]      rd_d;
  logic [MEM_AW-1:0] ma;
  logic [7:0]       mem_rd;
  logic [7:0]       imm;
  exu_pkg::exu_op_t op;
  logic [7:0]       alu_res;
  logic             alu_wr_acc;
  logic             alu_wr_mem;
  logic             alu_z_upd;
  logic             alu_c_upd;
  logic             alu_c_new;

  assign hrdata     = hrdata_q;
  assign hreadyout  = hready_q;
  assign hresp      = hresp_q;
  assign power_down = pdown_q;

  assign addr_take = hsel & hready & htrans[`EXU_HTRANS_NS];
  assign wr_hit    = dp_vld_q & dp_wr_q & hready;
  assign exec      = (st_q == exu_pkg::EXU_ST_EXEC);
  assign pop_cyc   = (st_q == exu_pkg::EXU_ST_POP);

  assign op  = exu_pkg::exu_op_t'(instr_q[`EXU_F_OP_LSB +: `EXU_F_OP_W]);
  assign ma  = instr_q[`EXU_F_MA_LSB +: MEM_AW];
  assign imm = instr_q[`EXU_F_ARG_LSB +: 8];
  assign mem_rd = mem_q[ma];

  exu_alu u_alu (
    .op     (op),
    .mem_in (mem_rd),
    .acc_in (acc_q),
    .imm_in (imm),
    .c_in   (flags_q[`EXU_FLG_C]),
    .res    (alu_res),
    .wr_acc (alu_wr_acc),
    .wr_mem (alu_wr_mem),
    .z_upd  (alu_z_upd),
    .c_upd  (alu_c_upd),
    .c_new  (alu_c_new)
  );

  // Address phase capture. Reads get one wait state so that the data
  // phase sees every write that went before it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_vld_q <= 1'b0;
      dp_wr_q  <= 1'b0;
      dp_adr_q <= 8'h00;
    end else if (hready) begin
      dp_vld_q <= addr_take;
      dp_wr_q  <= hwrite;
      dp_adr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      hready_q <= !(addr_take && !hwrite);
      hresp_q  <= 1'b0;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (dp_adr_q)
      `EXU_OFS_INSTR:  rd_d = instr_q;
      `EXU_OFS_ACC:    rd_d[7:0] = acc_q;
      `EXU_OFS_FLAGS:  rd_d[7:0] = flags_q;
      `EXU_OFS_PC:     rd_d[PC_W-1:0] = pc_q;
      `EXU_OFS_MADDR:  rd_d[MEM_AW-1:0] = maddr_q;
      `EXU_OFS_MDATA:  rd_d[7:0] = mem_q[maddr_q];
      `EXU_OFS_STATUS: begin
        rd_d[$bits(exu_pkg::exu_state_t)-1:0] = st_q;
        rd_d[`EXU_STAT_SP_LSB +: SP_W]        = sp_q;
      end
      `EXU_OFS_IRQC:   rd_d[7:0] = irq_control_reg_q;
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (dp_vld_q && !dp_wr_q && !hready_q) begin
      hrdata_q <= rd_d;
    end
  end

  // Sequencer. In sleep nothing executes and the watchdog is frozen,
  // which stands in for the stopped system clock.
  always_comb begin
    st_d = st_q;
    case (st_q)
      exu_pkg::EXU_ST_IDLE: begin
        if (wr_hit && dp_adr_q == `EXU_OFS_INSTR) begin
          st_d = exu_pkg::EXU_ST_EXEC;
        end
      end
      exu_pkg::EXU_ST_EXEC: begin
        if (op == exu_pkg::EXU_POP_PC || op == exu_pkg::EXU_POP_PC_VAL ||
            op == exu_pkg::EXU_IRQ_EXIT) begin
          st_d = exu_pkg::EXU_ST_POP;
        end else if (op == exu_pkg::EXU_SLEEP) begin
          st_d = exu_pkg::EXU_ST_SLEEP;
        end else begin
          st_d = exu_pkg::EXU_ST_IDLE;
        end
      end
      exu_pkg::EXU_ST_POP: begin
        st_d = exu_pkg::EXU_ST_IDLE;
      end
      exu_pkg::EXU_ST_SLEEP: begin
        if (wr_hit && dp_adr_q == `EXU_OFS_WAKE) begin
          st_d = exu_pkg::EXU_ST_IDLE;
        end
      end
      default: begin
        st_d = exu_pkg::EXU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= exu_pkg::EXU_ST_IDLE;
      pdown_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      pdown_q <= (st_d == exu_pkg::EXU_ST_SLEEP);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_q <= 32'h0000_0000;
    end else if (st_q == exu_pkg::EXU_ST_IDLE && wr_hit && dp_adr_q == `EXU_OFS_INSTR) begin
      instr_q <= hwdata;
    end
  end

  // Data memory holds its contents through sleep; it has no reset.
  always_ff @(posedge hclk) begin
    if (exec && alu_wr_mem) begin
      mem_q[ma] <= alu_res;
    end else if (wr_hit && dp_adr_q == `EXU_OFS_MDATA) begin
      mem_q[maddr_q] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      maddr_q <= '0;
    end else if (wr_hit && dp_adr_q == `EXU_OFS_MADDR) begin
      maddr_q <= hwdata[MEM_AW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= `EXU_ACC_RST;
    end else if (exec && alu_wr_acc) begin
      acc_q <= alu_res;
    end else if (wr_hit && dp_adr_q == `EXU_OFS_ACC) begin
      acc_q <= hwdata[7:0];
    end
  end

  // Flags start from their old value; only the bits an instruction names
  // are touched. A sleep clear in the same cycle as a watchdog overflow wins; a bus write to the flags loses to it.
  always_comb begin
    flags_d = flags_q;
    if (wr_hit && dp_adr_q == `EXU_OFS_FLAGS) begin
      flags_d = hwdata[7:0];
    end
    if (exec) begin
      if (alu_z_upd) begin
        flags_d[`EXU_FLG_Z] = (alu_res == 8'h00);
      end
      if (alu_c_upd) begin
        flags_d[`EXU_FLG_C] = alu_c_new;
      end
      if (op == exu_pkg::EXU_SLEEP) begin
        flags_d[`EXU_FLG_PWR_DOWN]   = 1'b1;
        flags_d[`EXU_FLG_WD_TIMEOUT] = 1'b0;
      end
    end
    if (wd_ovf) begin
      flags_d[`EXU_FLG_WD_TIMEOUT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= `EXU_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Program counter.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= '0;
    end else if (exec) begin
      case (op)
        exu_pkg::EXU_JUMP: begin
          pc_q[`EXU_JUMP_W-1:0] <= instr_q[`EXU_F_ARG_LSB +: `EXU_JUMP_W];
        end
        exu_pkg::EXU_POP_PC, exu_pkg::EXU_POP_PC_VAL, exu_pkg::EXU_IRQ_EXIT: begin
          pc_q <= pc_q;
        end
        default: begin
          pc_q <= pc_q + 1'b1;
        end
      endcase
    end else if (pop_cyc) begin
      pc_q <= stk_q[sp_q - 1'b1];
    end else if (wr_hit && dp_adr_q == `EXU_OFS_PC && st_q == exu_pkg::EXU_ST_IDLE) begin
      pc_q <= hwdata[PC_W-1:0];
    end
  end

  // Hardware stack wraps around; software fills it through the push port.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= '0;
    end else if (pop_cyc) begin
      sp_q <= sp_q - 1'b1;
    end else if (wr_hit && dp_adr_q == `EXU_OFS_STACK) begin
      sp_q <= sp_q + 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (!pop_cyc && wr_hit && dp_adr_q == `EXU_OFS_STACK) begin
      stk_q[sp_q] <= hwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_control_reg_q <= `EXU_IRQC_RST;
    end else if (pop_cyc && op == exu_pkg::EXU_IRQ_EXIT) begin
      irq_control_reg_q[`EXU_GIE_BIT] <= 1'b1;
    end else if (wr_hit && dp_adr_q == `EXU_OFS_IRQC) begin
      irq_control_reg_q <= hwdata[7:0];
    end
  end

  // Watchdog: prescaler feeds the counter, overflow raises the time-out.
  assign wd_clr = exec && (op == exu_pkg::EXU_SLEEP);
  assign wd_ovf = (st_q != exu_pkg::EXU_ST_SLEEP) && !wd_clr &&
                  (&wd_pre_q) && (&watchdog_counter_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_pre_q           <= '0;
      watchdog_counter_q <= '0;
    end else if (wd_clr) begin
      wd_pre_q           <= '0;
      watchdog_counter_q <= '0;
    end else if (st_q != exu_pkg::EXU_ST_SLEEP) begin
      wd_pre_q <= wd_pre_q + 1'b1;
      if (&wd_pre_q) begin
        watchdog_counter_q <= watchdog_counter_q + 1'b1;
      end
    end
  end

endmodule

// [tb/exu_core_monitor.sv]
`timescale 1ns/1ps
`include "exu_params.svh"
module exu_core_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Power state
  input wire logic        power_down
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic       take;
  logic       wake;
  logic       rd_q;
  logic       wr_q;
  logic       wk_q;
  logic [7:0] ad_q;
  logic [3:0] since_q;

  assign take = hsel && hready && htrans[1];
  assign wake = wr_q && ad_q == `EXU_OFS_WAKE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wk_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      rd_q <= take && !hwrite;
      wr_q <= take && hwrite;
      wk_q <= wake;
      ad_q <= haddr[7:0];
    end
  end

  // Saturating age of the last instruction write, so sleep entry can be tied to its cause.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_q <= 4'hf;
    end else if (wr_q && ad_q == `EXU_OFS_INSTR) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hf) begin
      since_q <= since_q + 4'h1;
    end
  end

  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence rd_status;
    take && !hwrite && haddr[7:0] == `EXU_OFS_STATUS;
  endsequence

  a_read_one_wait: assert property (take && !hwrite |=> rd_wait)
    else $error("read did not insert exactly one wait state");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_unmapped_reads_zero: assert property (take && !hwrite && haddr[7:0] > `EXU_OFS_STACK |=> rd_wait ##0 hrdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_rdata_holds: assert property ($changed(hrdata) |-> $past(rd_q))
    else $error("read data changed without a read");
  a_sleep_entry: assert property ($rose(power_down) |-> since_q <= 4'h3)
    else $error("power down entered without an instruction");
  a_sleep_holds: assert property (power_down && !wake && !wk_q |=> power_down)
    else $error("power down left without wake write");
  a_wake_leaves: assert property (wake && power_down |-> ##[1:3] !power_down)
    else $error("wake write did not end power down");
  a_sleep_status: assert property (rd_status ##1 power_down ##1 hreadyout |-> hrdata[1:0] == 2'h3)
    else $error("status did not show sleep state");
endmodule

bind exu_core exu_core_monitor mon_u (
  .hclk      (hclk),
  .hresetn   (hresetn),
  .hsel      (hsel),
  .haddr     (haddr),
  .htrans    (htrans),
  .hwrite    (hwrite),
  .hready    (hready),
  .hrdata    (hrdata),
  .hreadyout (hreadyout),
  .hresp     (hresp),
  .power_down(power_down)
);

// [tb/exu_core_bench.sv]
`timescale 1ns/1ps
`include "exu_params.svh"
module exu_core_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        power_down;
  logic [31:0] rd;
  logic [1:0]  st0;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;

  always #12.5 hclk = ~hclk;

  exu_core dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_down(power_down));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; entered just after a rising edge, returns at the edge ending the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic reg_is(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // The first status read lands in the cycle after execution, so it shows a pending pop.
  task automatic run(input logic [31:0] ins);
    bus(1'b1, `EXU_OFS_INSTR, ins);
    bus(1'b0, `EXU_OFS_STATUS, 32'h0);
    st0 = rd[1:0];
    while (rd[1:0] !== 2'h0)
      bus(1'b0, `EXU_OFS_STATUS, 32'h0);
  endtask

  function automatic logic [23:0] mdl(input logic [4:0] op, input logic [7:0] m, a, i, f);
    logic [7:0] r;
    case (op)
      5'h01, 5'h02: r = m - 8'h01;
      5'h04, 5'h05: r = m + 8'h01;
      5'h08: r = i;
      5'h09: r = a;
      5'h0a, 5'h0c: r = a | m;
      5'h0b: r = a | i;
      5'h10, 5'h11: r = {m[6:0], m[7]};
      5'h12, 5'h13: r = {m[6:0], f[0]};
      5'h14, 5'h15: r = {m[0], m[7:1]};
      default: r = m;
    endcase
    if (op inside {5'h01, 5'h02, 5'h04, 5'h05, 5'h0a, 5'h0b, 5'h0c})
      f[2] = (r == 8'h00);
    if (op inside {5'h12, 5'h13})
      f[0] = m[7];
    if (op inside {5'h02, 5'h05, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h11, 5'h13, 5'h15})
      a = r;
    if (op inside {5'h01, 5'h04, 5'h09, 5'h0c, 5'h10, 5'h12, 5'h14})
      m = r;
    return {a, m, f};
  endfunction

  task automatic t_reset();
    reg_is("acc", `EXU_OFS_ACC, 32'h0);
    reg_is("flags", `EXU_OFS_FLAGS, 32'h0);
    reg_is("pc", `EXU_OFS_PC, 32'h0);
    reg_is("irqc", `EXU_OFS_IRQC, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    reg_is("unmapped", 8'h40, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_alu();
    logic [7:0]  m [3] = '{8'h01, 8'hff, 8'h96};
    logic [7:0]  a [3] = '{8'h00, 8'h00, 8'h41};
    logic [7:0]  f [3] = '{8'had, 8'h52, 8'h52};
    logic [23:0] e;
    logic [15:0] pc;
    // One code past the last defined opcode must behave as an idle.
    for (int op = 0; op < 23; op++) begin
      if (op inside {3, 6, 13, 14, 15})
        continue;
      for (int k = 0; k < 3; k++) begin
        bus(1'b1, `EXU_OFS_MADDR, 32'h3c);
        bus(1'b1, `EXU_OFS_MDATA, {24'h0, m[k]});
        run({8'h00, a[k], 8'h3c, 8'h08});
        bus(1'b1, `EXU_OFS_FLAGS, {24'h0, f[k]});
        bus(1'b0, `EXU_OFS_PC, 32'h0);
        pc = rd[15:0] + 16'h1;
        e = mdl(op[4:0], m[k], a[k], 8'h28, f[k]);
        run({8'h00, 8'h28, 8'h3c, 3'h0, op[4:0]});
        check("single cycle", {30'h0, st0}, 32'h0);
        reg_is("acc", `EXU_OFS_ACC, {24'h0, e[23:16]});
        reg_is("mem", `EXU_OFS_MDATA, {24'h0, e[15:8]});
        reg_is("flags", `EXU_OFS_FLAGS, {24'h0, e[7:0]});
        reg_is("pc", `EXU_OFS_PC, {16'h0, pc});
      end
    end
    $display("alu test done");
  endtask

  task automatic t_flow();
    bus(1'b1, `EXU_OFS_PC, 32'he000);
    bus(1'b1, `EXU_OFS_FLAGS, 32'had);
    run({3'h0, 13'h1abc, 8'h3c, 8'h06});
    reg_is("jump pc", `EXU_OFS_PC, 32'hfabc);
    bus(1'b1, `EXU_OFS_STACK, 32'h1234);
    run({8'h00, 8'h77, 8'h3c, 8'h0d});
    check("pop state", {30'h0, st0}, 32'h2);
    reg_is("ret pc", `EXU_OFS_PC, 32'h1234);
    bus(1'b1, `EXU_OFS_STACK, 32'h0456);
    run({8'h00, 8'h77, 8'h3c, 8'h0e});
    reg_is("retv acc", `EXU_OFS_ACC, 32'h77);
    reg_is("retv pc", `EXU_OFS_PC, 32'h0456);
    bus(1'b1, `EXU_OFS_IRQC, 32'h0);
    bus(1'b1, `EXU_OFS_STACK, 32'h0789);
    run({8'h00, 8'h00, 8'h3c, 8'h0f});
    reg_is("irq_exit_op pc", `EXU_OFS_PC, 32'h0789);
    reg_is("irq_exit_op irqc", `EXU_OFS_IRQC, 32'h1);
    reg_is("flow flags", `EXU_OFS_FLAGS, 32'had);
    $display("flow test done");
  endtask

  task automatic t_sleep();
    bus(1'b1, `EXU_OFS_MADDR, 32'h3c);
    bus(1'b1, `EXU_OFS_MDATA, 32'h5a);
    run({8'h00, 8'hc3, 8'h3c, 8'h08});
    bus(1'b1, `EXU_OFS_FLAGS, 32'h2f);
    bus(1'b1, `EXU_OFS_PC, 32'h0100);
    bus(1'b1, `EXU_OFS_INSTR, {24'h3c, 8'h03});
    reg_is("sleep state", `EXU_OFS_STATUS, 32'h3);
    check("power down", {31'h0, power_down}, 32'h1);
    reg_is("sleep flags", `EXU_OFS_FLAGS, 32'h1f);
    reg_is("sleep pc", `EXU_OFS_PC, 32'h0101);
    bus(1'b1, `EXU_OFS_INSTR, {8'h00, 8'hee, 8'h3c, 8'h08});
    reg_is("kept acc", `EXU_OFS_ACC, 32'hc3);
    reg_is("kept mem", `EXU_OFS_MDATA, 32'h5a);
    bus(1'b1, `EXU_OFS_WAKE, 32'h1);
    reg_is("woken", `EXU_OFS_STATUS, 32'h0);
    check("awake", {31'h0, power_down}, 32'h0);
    $display("sleep test done");
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_alu();
    t_flow();
    t_sleep();
    give_verdict();
  end
endmodule
